// file: motor_pulse_unit.sv
/*
  Motor pulse unit: period and six duty compare registers for a three-phase
  bridge, cycle counter, duty match events with sticky status and mask.
  Assumes a single 100 MHz clock, synchronous inputs and a register master
  that strobes one cycle at a time and takes read data the next cycle.
*/
// How it works
// - software-written 16-bit period sets the shared counter cycle length.
// - each high-side output has its own 16-bit duty compare value.
// - each low-side output has its own 16-bit duty, independent of high side.
// - a zero duty gives no switching and no match event.
// - enable clear holds the counter logic in reset; registers stay reachable.
// - with adc trigger mode off, a duty match raises that channel's event.
`timescale 1ns/1ps
`default_nettype none
module motor_pulse_unit #(
  parameter int unsigned W = pwm_pkg::DATA_W
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             irq,
  output logic             phase_u_high_out,
  output logic             phase_v_high_out,
  output logic             phase_w_high_out,
  output logic             phase_u_low_out,
  output logic             phase_v_low_out,
  output logic             phase_w_low_out
);
  localparam int unsigned N = pwm_pkg::NUM_CH;
  localparam int unsigned SW = pwm_pkg::STAT_W;

  typedef struct packed {
    pwm_pkg::run_state_type st;
    logic [W-1:0]           cycle_length;
    logic [N-1:0][W-1:0]    duty;
    logic                   unit_run_enable;
    logic [N-1:0]           adc_trigger_mode_sel;
    logic [SW-1:0]          status;
    logic [SW-1:0]          mask;
    logic [W-1:0]           count;
    logic [31:0]            rdata;
  } unit_state_type;

  unit_state_type s_r;
  unit_state_type s_nxt;

  cmp_if #(.W(W), .N(N)) cmp ();

  duty_compare #(.W(W), .N(N)) u_cmp (
    .clk    (clk),
    .resetn (resetn),
    .bus    (cmp.cmp)
  );

  // address to register select, shared by read and write paths
  function automatic pwm_pkg::reg_sel_type decode(input logic [31:0] a);
    case (a)
      pwm_pkg::ADDR_PERIOD:   decode = pwm_pkg::sel_period;
      pwm_pkg::ADDR_DUTY_PHASE_U_HIGH,
      pwm_pkg::ADDR_DUTY_PHASE_V_HIGH,
      pwm_pkg::ADDR_DUTY_PHASE_W_HIGH,
      pwm_pkg::ADDR_DUTY_PHASE_U_LOW,
      pwm_pkg::ADDR_DUTY_PHASE_V_LOW,
      pwm_pkg::ADDR_DUTY_PHASE_W_LOW:  decode = pwm_pkg::sel_duty;
      pwm_pkg::ADDR_CTRL:     decode = pwm_pkg::sel_ctrl;
      pwm_pkg::ADDR_STATUS:   decode = pwm_pkg::sel_status;
      pwm_pkg::ADDR_MASK:     decode = pwm_pkg::sel_mask;
      pwm_pkg::ADDR_ADC_MODE: decode = pwm_pkg::sel_adc_mode;
      pwm_pkg::ADDR_COUNT:    decode = pwm_pkg::sel_count;
      default:                decode = pwm_pkg::sel_none;
    endcase
  endfunction

  // duty address to channel index
  function automatic logic [2:0] duty_ch(input logic [31:0] a);
    case (a)
      pwm_pkg::ADDR_DUTY_PHASE_U_HIGH: duty_ch = 3'(pwm_pkg::CH_UH);
      pwm_pkg::ADDR_DUTY_PHASE_V_HIGH: duty_ch = 3'(pwm_pkg::CH_VH);
      pwm_pkg::ADDR_DUTY_PHASE_W_HIGH: duty_ch = 3'(pwm_pkg::CH_WH);
      pwm_pkg::ADDR_DUTY_PHASE_U_LOW: duty_ch = 3'(pwm_pkg::CH_UL);
      pwm_pkg::ADDR_DUTY_PHASE_V_LOW: duty_ch = 3'(pwm_pkg::CH_VL);
      default:               duty_ch = 3'(pwm_pkg::CH_WL);
    endcase
  endfunction

  pwm_pkg::reg_sel_type wsel;
  pwm_pkg::reg_sel_type rsel;
  logic                 running;
  logic                 wrap;
  logic [SW-1:0]        events;
  logic [SW-1:0]        clear;

  assign wsel    = wr ? decode(addr) : pwm_pkg::sel_none;
  assign rsel    = rd ? decode(addr) : pwm_pkg::sel_none;
  assign running = (s_r.st == pwm_pkg::st_run) && s_r.unit_run_enable;
  assign wrap    = running && (s_r.count >= s_r.cycle_length);

  always_comb begin
    events = '0;
    events[N-1:0] = cmp.match & ~s_r.adc_trigger_mode_sel;
    events[pwm_pkg::STAT_PERIOD_BIT] = wrap;
    clear = (wsel == pwm_pkg::sel_status) ? wdata[SW-1:0] : '0;
  end

  always_comb begin
    s_nxt = s_r;

    // counter and run state
    case (s_r.st)
      pwm_pkg::st_idle: begin
        s_nxt.count = '0;
        if (s_r.unit_run_enable) begin
          s_nxt.st = pwm_pkg::st_run;
        end
      end
      pwm_pkg::st_run: begin
        if (!s_r.unit_run_enable) begin
          s_nxt.st    = pwm_pkg::st_idle;
          s_nxt.count = '0;
        end else if (wrap) begin
          s_nxt.count = '0;
        end else begin
          s_nxt.count = s_r.count + W'(1);
        end
      end
      default: begin
        s_nxt.st    = pwm_pkg::st_idle;
        s_nxt.count = '0;
      end
    endcase

    // register writes stay open while the counter is held
    case (wsel)
      pwm_pkg::sel_period:   s_nxt.cycle_length = wdata[W-1:0];
      pwm_pkg::sel_duty:     s_nxt.duty[duty_ch(addr)] = wdata[W-1:0];
      pwm_pkg::sel_ctrl:     s_nxt.unit_run_enable = wdata[pwm_pkg::CTRL_EN_BIT];
      pwm_pkg::sel_mask:     s_nxt.mask = wdata[SW-1:0];
      pwm_pkg::sel_adc_mode: s_nxt.adc_trigger_mode_sel = wdata[N-1:0];
      default: ;
    endcase

    // an event in the clearing cycle survives
    s_nxt.status = (s_r.status & ~clear) | events;

    // read data stands for the one cycle after the strobe only
    case (rsel)
      pwm_pkg::sel_period:   s_nxt.rdata = {16'h0000, s_r.cycle_length};
      pwm_pkg::sel_duty:     s_nxt.rdata = {16'h0000, s_r.duty[duty_ch(addr)]};
      pwm_pkg::sel_ctrl:     s_nxt.rdata = {31'h0000_0000, s_r.unit_run_enable};
      pwm_pkg::sel_status:   s_nxt.rdata = {24'h00_0000, s_r.status};
      pwm_pkg::sel_mask:     s_nxt.rdata = {24'h00_0000, s_r.mask};
      pwm_pkg::sel_adc_mode: s_nxt.rdata = {26'h000_0000, s_r.adc_trigger_mode_sel};
      pwm_pkg::sel_count:    s_nxt.rdata = {16'h0000, s_r.count};
      default:               s_nxt.rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r.st                   <= pwm_pkg::st_idle;
      s_r.cycle_length         <= pwm_pkg::PERIOD_RST;
      s_r.duty                 <= {N{pwm_pkg::DUTY_RST}};
      s_r.unit_run_enable      <= 1'b0;
      s_r.adc_trigger_mode_sel <= '0;
      s_r.status               <= '0;
      s_r.mask                 <= '0;
      s_r.count                <= '0;
      s_r.rdata                <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cmp.count = s_r.count;
  assign cmp.duty  = s_r.duty;
  assign cmp.run   = running;

  assign rdata            = s_r.rdata;
  assign irq              = |(s_r.status & s_r.mask);
  assign phase_u_high_out = cmp.level[pwm_pkg::CH_UH];
  assign phase_v_high_out = cmp.level[pwm_pkg::CH_VH];
  assign phase_w_high_out = cmp.level[pwm_pkg::CH_WH];
  assign phase_u_low_out  = cmp.level[pwm_pkg::CH_UL];
  assign phase_v_low_out  = cmp.level[pwm_pkg::CH_VL];
  assign phase_w_low_out  = cmp.level[pwm_pkg::CH_WL];

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  period_write_a: assert property (
    wr && addr == pwm_pkg::ADDR_PERIOD |=> s_r.cycle_length == $past(wdata[15:0]))
    else $error("period write not stored");
  cycle_wrap_a: assert property (
    running && s_r.count >= s_r.cycle_length |=> s_r.count == '0)
    else $error("counter did not wrap at period");
  duty_phase_u_high_write_a: assert property (
    wr && addr == pwm_pkg::ADDR_DUTY_PHASE_U_HIGH
    |=> s_r.duty[pwm_pkg::CH_UH] == $past(wdata[15:0])
        && s_r.duty[pwm_pkg::CH_VH] == $past(s_r.duty[pwm_pkg::CH_VH]))
    else $error("high side duty write wrong");
  duty_phase_u_low_write_a: assert property (
    wr && addr == pwm_pkg::ADDR_DUTY_PHASE_U_LOW
    |=> s_r.duty[pwm_pkg::CH_UL] == $past(wdata[15:0])
        && s_r.duty[pwm_pkg::CH_UH] == $past(s_r.duty[pwm_pkg::CH_UH]))
    else $error("low side duty write wrong");
  idle_hold_a: assert property (
    !s_r.unit_run_enable |=> s_r.count == '0 && cmp.level == '0)
    else $error("counter logic active while disabled");
  event_set_a: assert property (
    |(cmp.match & ~s_r.adc_trigger_mode_sel)
    |=> (s_r.status[N-1:0] & $past(cmp.match & ~s_r.adc_trigger_mode_sel))
        == $past(cmp.match & ~s_r.adc_trigger_mode_sel))
    else $error("duty match event lost");
  adc_block_a: assert property (
    s_r.adc_trigger_mode_sel[0] && !s_r.status[0] |=> !s_r.status[0])
    else $error("duty event raised in adc trigger mode");
  zero_event_a: assert property (
    s_r.duty[pwm_pkg::CH_UH] == '0 |-> !cmp.match[pwm_pkg::CH_UH])
    else $error("zero duty produced a match");
  read_late_a: assert property (
    rd && addr == pwm_pkg::ADDR_COUNT
    |=> rdata == {16'h0000, $past(s_r.count)} ##1 (rdata == '0 || $past(rd)))
    else $error("read data timing wrong");
  duty_phase_v_high_write_a: assert property (
    wr && addr == pwm_pkg::ADDR_DUTY_PHASE_V_HIGH |=> s_r.duty[pwm_pkg::CH_VH] == $past(wdata[15:0]))
    else $error("v high duty write not stored");
  duty_phase_w_high_write_a: assert property (
    wr && addr == pwm_pkg::ADDR_DUTY_PHASE_W_HIGH |=> s_r.duty[pwm_pkg::CH_WH] == $past(wdata[15:0]))
    else $error("w high duty write not stored");
  duty_phase_v_low_write_a: assert property (
    wr && addr == pwm_pkg::ADDR_DUTY_PHASE_V_LOW |=> s_r.duty[pwm_pkg::CH_VL] == $past(wdata[15:0]))
    else $error("v low duty write not stored");
  duty_phase_w_low_write_a: assert property (
    wr && addr == pwm_pkg::ADDR_DUTY_PHASE_W_LOW |=> s_r.duty[pwm_pkg::CH_WL] == $past(wdata[15:0]))
    else $error("w low duty write not stored");
  ctrl_write_a: assert property (
    wr && addr == pwm_pkg::ADDR_CTRL
    |=> s_r.unit_run_enable == $past(wdata[pwm_pkg::CTRL_EN_BIT]))
    else $error("run enable write not stored");
  mask_write_a: assert property (
    wr && addr == pwm_pkg::ADDR_MASK |=> s_r.mask == $past(wdata[SW-1:0]))
    else $error("mask write not stored");
  adc_write_a: assert property (
    wr && addr == pwm_pkg::ADDR_ADC_MODE |=> s_r.adc_trigger_mode_sel == $past(wdata[N-1:0]))
    else $error("trigger mode write not stored");
  period_keep_a: assert property (
    !(wr && addr == pwm_pkg::ADDR_PERIOD) |=> $stable(s_r.cycle_length))
    else $error("period changed without a write");
  duty_keep_a: assert property (
    !wr |=> $stable(s_r.duty))
    else $error("duty changed without a write");
  write_unmapped_a: assert property (
    wr && wsel == pwm_pkg::sel_none |=> $stable(s_r.cycle_length) && $stable(s_r.duty))
    else $error("unmapped write changed a register");
  start_delay_a: assert property (
    s_r.st == pwm_pkg::st_idle && s_r.unit_run_enable
    |=> s_r.st == pwm_pkg::st_run && s_r.count == '0)
    else $error("counter start not from zero");
  count_step_a: assert property (
    running && !wrap |=> s_r.count == $past(s_r.count) + W'(1))
    else $error("counter skipped a step");
  stopped_quiet_a: assert property (
    !running |=> s_r.count == '0 && cmp.level == '0)
    else $error("outputs active while stopped");
  wrap_event_a: assert property (
    wrap |=> s_r.status[pwm_pkg::STAT_PERIOD_BIT])
    else $error("period wrap event lost");
  status_sticky_a: assert property (
    !(wr && addr == pwm_pkg::ADDR_STATUS)
    |=> (s_r.status & $past(s_r.status)) == $past(s_r.status))
    else $error("status bit fell without a clear");
  status_clear_a: assert property (
    wr && addr == pwm_pkg::ADDR_STATUS && wdata[0] && !cmp.match[0] |=> !s_r.status[0])
    else $error("status clear ignored");
  read_idle_a: assert property (
    !rd |=> rdata == '0)
    else $error("read data outside its cycle");
  read_unmapped_a: assert property (
    rd && rsel == pwm_pkg::sel_none |=> rdata == '0)
    else $error("unmapped read not zero");
  read_period_a: assert property (
    rd && addr == pwm_pkg::ADDR_PERIOD
    |=> rdata == {16'h0000, $past(s_r.cycle_length)})
    else $error("period read wrong");
  read_duty_a: assert property (
    rd && addr == pwm_pkg::ADDR_DUTY_PHASE_V_LOW
    |=> rdata == {16'h0000, $past(s_r.duty[pwm_pkg::CH_VL])})
    else $error("duty read wrong");
  read_ctrl_a: assert property (
    rd && addr == pwm_pkg::ADDR_CTRL
    |=> rdata == {31'h0000_0000, $past(s_r.unit_run_enable)})
    else $error("run enable read wrong");
  read_status_a: assert property (
    rd && addr == pwm_pkg::ADDR_STATUS |=> rdata == {24'h00_0000, $past(s_r.status)})
    else $error("status read wrong");
  read_mask_a: assert property (
    rd && addr == pwm_pkg::ADDR_MASK |=> rdata == {24'h00_0000, $past(s_r.mask)})
    else $error("mask read wrong");
  read_adc_a: assert property (
    rd && addr == pwm_pkg::ADDR_ADC_MODE
    |=> rdata == {26'h000_0000, $past(s_r.adc_trigger_mode_sel)})
    else $error("trigger mode read wrong");
endmodule
`default_nettype wire

// file: pwm_pkg.sv
/*
  Constants for the three-phase motor pulse unit: register byte addresses,
  field positions, reset values and the channel order shared by all files.
  Assumes a 32-bit byte address from the register port.
*/
`default_nettype none
package pwm_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_CH = 6;

  // register byte addresses
  localparam logic [31:0] ADDR_PERIOD   = 32'h4000_4004;
  localparam logic [31:0] ADDR_DUTY_PHASE_U_HIGH  = 32'h4000_4010;
  localparam logic [31:0] ADDR_DUTY_PHASE_V_HIGH  = 32'h4000_4014;
  localparam logic [31:0] ADDR_DUTY_PHASE_W_HIGH  = 32'h4000_4018;
  localparam logic [31:0] ADDR_DUTY_PHASE_U_LOW  = 32'h4000_401c;
  localparam logic [31:0] ADDR_DUTY_PHASE_V_LOW  = 32'h4000_4020;
  localparam logic [31:0] ADDR_DUTY_PHASE_W_LOW  = 32'h4000_4024;
  localparam logic [31:0] ADDR_CTRL     = 32'h4000_4028;
  localparam logic [31:0] ADDR_STATUS   = 32'h4000_4030;
  localparam logic [31:0] ADDR_MASK     = 32'h4000_4034;
  localparam logic [31:0] ADDR_ADC_MODE = 32'h4000_4038;
  localparam logic [31:0] ADDR_COUNT    = 32'h4000_403c;

  // channel index = status bit position
  localparam int unsigned CH_UL = 0;
  localparam int unsigned CH_VL = 1;
  localparam int unsigned CH_WL = 2;
  localparam int unsigned CH_UH = 3;
  localparam int unsigned CH_VH = 4;
  localparam int unsigned CH_WH = 5;

  // fields
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned STAT_PERIOD_BIT = 7;
  localparam int unsigned STAT_W         = 8;

  // reset values
  localparam logic [15:0] PERIOD_RST = 16'h0002;
  localparam logic [15:0] DUTY_RST   = 16'h0001;

  // register select codes from the address decoder
  typedef enum logic [3:0] {
    sel_none, sel_period, sel_duty, sel_ctrl, sel_status, sel_mask, sel_adc_mode, sel_count
  } reg_sel_type;

  typedef enum logic {
    st_idle = 1'b0,
    st_run  = 1'b1
  } run_state_type;
endpackage
`default_nettype wire

// file: cmp_if.sv
/*
  Carrier between the unit controller and its duty comparator.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface cmp_if #(parameter int unsigned W = 16, parameter int unsigned N = 6);
  logic [W-1:0]        count;
  logic [N-1:0][W-1:0] duty;
  logic                run;
  logic [N-1:0]        level;
  logic [N-1:0]        match;
  modport ctrl (output count, output duty, output run, input level, input match);
  modport cmp  (input count, input duty, input run, output level, output match);
endinterface
`default_nettype wire

// file: duty_compare.sv
/*
  Six duty comparators against the shared cycle counter. Levels are registered,
  matches are combinational one-cycle pulses.
  Assumes the controller holds count at zero and run low while disabled.
*/
`timescale 1ns/1ps
`default_nettype none
module duty_compare #(
  parameter int unsigned W = 16,
  parameter int unsigned N = 6
) (
  input  wire logic clk,
  input  wire logic resetn,
  cmp_if.cmp        bus
);
  typedef struct packed {
    logic [N-1:0] level;
  } cmp_state_type;

  cmp_state_type st_r;
  cmp_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < N; i++) begin
      // zero duty never switches
      st_nxt.level[i] = bus.run && (bus.duty[i] != '0) && (bus.count < bus.duty[i]);
      bus.match[i]    = bus.run && (bus.duty[i] != '0) && (bus.count == bus.duty[i]);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.level = st_r.level;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  zero_duty_a: assert property (bus.duty[3] == '0 |=> !bus.level[3])
    else $error("zero duty channel switched");
  high_side_a: assert property (
    bus.run && bus.duty[3] != '0 && bus.count < bus.duty[3] |=> bus.level[3])
    else $error("high side level missing below its duty");
endmodule
`default_nettype wire

// file: bridge_model.sv
/*
  Gate driver stand-in for the three-phase bridge: counts the clocks for
  which each of the six gate inputs is driven high.
  Assumes the bench clock and a clear input changed off the sampling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module bridge_model (
  input  wire logic             clk,
  input  wire logic             clr,
  input  wire logic [5:0]       gate,
  output logic      [5:0][15:0] hi_cnt
);
  // index order follows the status bits, low side first
  always_ff @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      hi_cnt[i] <= clr ? 16'h0000 : hi_cnt[i] + 16'(gate[i]);
    end
  end
endmodule
`default_nettype wire

// file: motor_pulse_unit_tb_top.sv
/*
  Self-checking bench for motor_pulse_unit: register access, pulse widths,
  match events and interrupt, zero duty and unit disable.
  Assumes the gate driver stand-in of bridge_model.sv on the six outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module motor_pulse_unit_tb_top;
  localparam logic [31:0] DA [6] = '{pwm_pkg::ADDR_DUTY_PHASE_U_LOW, pwm_pkg::ADDR_DUTY_PHASE_V_LOW,
    pwm_pkg::ADDR_DUTY_PHASE_W_LOW, pwm_pkg::ADDR_DUTY_PHASE_U_HIGH, pwm_pkg::ADDR_DUTY_PHASE_V_HIGH,
    pwm_pkg::ADDR_DUTY_PHASE_W_HIGH};
  logic             clk;
  logic             resetn;
  logic      [31:0] addr;
  logic      [31:0] wdata;
  logic             wr;
  logic             rd;
  logic      [31:0] rdata;
  logic             irq;
  wire       [5:0]  gate;
  logic             clr;
  logic [5:0][15:0] hi_cnt;
  logic      [31:0] d;
  int               err_total;
  int               checked;

  motor_pulse_unit dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .phase_u_high_out(gate[3]),
    .phase_v_high_out(gate[4]), .phase_w_high_out(gate[5]), .phase_u_low_out(gate[0]),
    .phase_v_low_out(gate[1]), .phase_w_low_out(gate[2]));
  bridge_model partner (.clk(clk), .clr(clr), .gate(gate), .hi_cnt(hi_cnt));

  function automatic logic [31:0] dv(input int i);
    return 32'h0000_0004 + 32'(2 * i);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [31:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // window of 33 clocks = one full cycle at period 0x20, any phase
  task automatic measure();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (33) @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic t_reset();
    // a write to an unmapped address must leave the period alone
    wr_reg(32'h4000_4000, 32'h0000_00ff);
    rd_reg(pwm_pkg::ADDR_PERIOD);
    chk(d, 32'h0000_0002);
    for (int i = 0; i < 6; i++) begin
      rd_reg(DA[i]);
      chk(d, 32'h0000_0001);
    end
    rd_reg(32'h4000_4000);
    chk(d, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test reset values done");
  endtask
  task automatic t_regs();
    // upper bits must be dropped, reads zero-extend
    wr_reg(pwm_pkg::ADDR_PERIOD, 32'hffff_0020);
    rd_reg(pwm_pkg::ADDR_PERIOD);
    chk(d, 32'h0000_0020);
    for (int i = 0; i < 6; i++) begin
      wr_reg(DA[i], dv(i));
    end
    for (int i = 0; i < 6; i++) begin
      rd_reg(DA[i]);
      chk(d, dv(i));
    end
    $display("test register access done");
  endtask
  task automatic t_run();
    wr_reg(pwm_pkg::ADDR_CTRL, 32'h0000_0001);
    rd_reg(pwm_pkg::ADDR_CTRL);
    chk(d, 32'h0000_0001);
    repeat (40) @(posedge clk);
    measure();
    for (int i = 0; i < 6; i++) begin
      chk({16'h0, hi_cnt[i]}, dv(i));
    end
    rd_reg(pwm_pkg::ADDR_STATUS);
    chk(d, 32'h0000_00bf);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test pulse widths done");
  endtask
  task automatic t_irq();
    wr_reg(pwm_pkg::ADDR_MASK, 32'h0000_0008);
    #1 chk({31'h0, irq}, 32'h0000_0001);
    wr_reg(pwm_pkg::ADDR_ADC_MODE, 32'h0000_003f);
    rd_reg(pwm_pkg::ADDR_ADC_MODE);
    chk(d, 32'h0000_003f);
    rd_reg(pwm_pkg::ADDR_MASK);
    chk(d, 32'h0000_0008);
    wr_reg(pwm_pkg::ADDR_STATUS, 32'h0000_003f);
    repeat (40) @(posedge clk);
    rd_reg(pwm_pkg::ADDR_STATUS);
    chk(d & 32'h0000_003f, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wr_reg(pwm_pkg::ADDR_ADC_MODE, 32'h0000_0000);
    repeat (40) @(posedge clk);
    rd_reg(pwm_pkg::ADDR_STATUS);
    chk(d & 32'h0000_003f, 32'h0000_003f);
    chk({31'h0, irq}, 32'h0000_0001);
    $display("test events and interrupt done");
  endtask
  task automatic t_zero();
    wr_reg(DA[pwm_pkg::CH_UH], 32'h0000_0000);
    // let a match from the old duty land before clearing
    repeat (2) @(posedge clk);
    wr_reg(pwm_pkg::ADDR_STATUS, 32'h0000_003f);
    measure();
    chk({16'h0, hi_cnt[pwm_pkg::CH_UH]}, 32'h0000_0000);
    chk({16'h0, hi_cnt[pwm_pkg::CH_VH]}, dv(pwm_pkg::CH_VH));
    rd_reg(pwm_pkg::ADDR_STATUS);
    chk(d & 32'h0000_003f, 32'h0000_0037);
    $display("test zero duty done");
  endtask
  task automatic t_disable();
    wr_reg(pwm_pkg::ADDR_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1 chk({26'h0, gate}, 32'h0000_0000);
    rd_reg(pwm_pkg::ADDR_COUNT);
    chk(d, 32'h0000_0000);
    wr_reg(pwm_pkg::ADDR_PERIOD, 32'h0000_0030);
    rd_reg(pwm_pkg::ADDR_PERIOD);
    chk(d, 32'h0000_0030);
    $display("test unit disable done");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // tests need about 280 clocks
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
  initial begin
    err_total = 0;
    checked   = 0;
    resetn    = 1'b0;
    addr      = 32'h0;
    wdata     = 32'h0;
    wr        = 1'b0;
    rd        = 1'b0;
    clr       = 1'b1;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_regs();
    t_run();
    t_irq();
    t_zero();
    t_disable();
    finish_test();
  end
endmodule
`default_nettype wire
